// ---- tb/rmsc_host_model.sv ----
// host model shifting framed commands and collecting replies
`timescale 1ns/1ps
`default_nettype none
module rmsc_host_model (
    input  wire logic clock,
    output logic      sclk,
    output logic      si,
    input  wire logic so
);
    initial begin
        sclk = 1'b0; // stands still outside frames
        si   = 1'b1;
    end
    // level held on the command input across a reset
    task automatic hold_si(input logic v);
        si = v;
    endtask
    // 14 rises for plain commands, 20 for replies; no reserved opcodes
    task automatic xfer(input logic [7:0] cmd, input int n_rise,
                        output logic [8:0] rsp);
        int k;
        rsp = 9'h1FF;
        @(negedge clock);
        for (k = 1; k <= n_rise; k++) begin
            si = (k == 1) ? 1'b0 : (k <= 9) ? cmd[k-2] : 1'b1;
            repeat (4) @(negedge clock);
            if (k >= 11 && k <= 19) begin
                rsp[k-11] = so;
            end
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            sclk = 1'b0;
        end
        si = 1'b1;
        repeat (12) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ---- tb/rmsc_mgmt_serial_tb.sv ----
// self-checking bench for the management serial command block
`timescale 1ns/1ps
`default_nettype none
module rmsc_mgmt_serial_tb;
    logic       clock    = 1'b0;
    logic       rst_n    = 1'b0;
    logic       test_sel = 1'b0;
    logic       up_conn  = 1'b1;
    logic       up_b     = 1'b0;
    logic       up_s     = 1'b0;
    logic       up_l     = 1'b0;
    logic       jab      = 1'b0;
    logic [7:0] tp_conn  = 8'hA5;
    logic [7:0] tp_rate  = 8'h3C;
    logic [7:0] tp_link  = 8'h41;
    logic [7:0] tp_pol   = 8'h96;
    logic       sclk, si, so, coltest_mask, activity_monitor_alt;
    logic       up_alt_algo, tp_alt_algo, up_disabled, up_part_idle;
    logic [7:0] tp_disabled, tp_reconnect, tp_link_fail;
    logic [7:0] tp_link_test_off, tp_pol_corr_en;
    logic [7:0] seen_rec  = 8'h00;
    logic [7:0] seen_fail = 8'h00;
    logic       seen_idle = 1'b0;
    logic       clr_seen  = 1'b0;
    logic [3:0] dis4;
    logic [8:0] rsp;
    int         fails      = 0;
    int         n_compared = 0;
    int         p;

    always #25 clock = ~clock;

    always @(posedge clock) begin
        if (clr_seen) begin
            seen_rec  <= 8'h00;
            seen_fail <= 8'h00;
            seen_idle <= 1'b0;
        end else begin
            seen_rec  <= seen_rec | tp_reconnect;
            seen_fail <= seen_fail | tp_link_fail;
            seen_idle <= seen_idle | up_part_idle;
        end
    end

    rmsc_host_model i_host (.clock(clock), .sclk(sclk), .si(si), .so(so));

    rmsc_mgmt_serial #(.PORTS(8), .VERSION(8'h5A)) i_rmsc_mgmt_serial (
        .clock(clock), .rst_n(rst_n), .sclk(sclk), .si(si),
        .test_sel(test_sel), .up_connected(up_conn),
        .up_rate_err_evt(up_b), .up_coltest_evt(up_s), .up_link_evt(up_l),
        .long_jabber_status(jab), .tp_connected(tp_conn),
        .tp_rate_err(tp_rate), .tp_link_pass(tp_link),
        .tp_pol_rev(tp_pol), .so(so), .coltest_mask(coltest_mask),
        .activity_monitor_alt(activity_monitor_alt),
        .up_alt_algo(up_alt_algo), .tp_alt_algo(tp_alt_algo),
        .up_disabled(up_disabled), .up_part_idle(up_part_idle),
        .tp_disabled(tp_disabled), .tp_reconnect(tp_reconnect),
        .tp_link_fail(tp_link_fail), .tp_link_test_off(tp_link_test_off),
        .tp_pol_corr_en(tp_pol_corr_en)
    );

    rmsc_mgmt_serial #(.PORTS(4)) i_rmsc_mgmt_serial_4 (
        .clock(clock), .rst_n(rst_n), .sclk(sclk), .si(si),
        .test_sel(test_sel), .up_connected(up_conn),
        .up_rate_err_evt(up_b), .up_coltest_evt(up_s), .up_link_evt(up_l),
        .long_jabber_status(jab), .tp_connected(tp_conn[3:0]),
        .tp_rate_err(tp_rate[3:0]), .tp_link_pass(tp_link[3:0]),
        .tp_pol_rev(tp_pol[3:0]), .so(), .coltest_mask(),
        .activity_monitor_alt(), .up_alt_algo(), .tp_alt_algo(),
        .up_disabled(), .up_part_idle(), .tp_disabled(dis4),
        .tp_reconnect(), .tp_link_fail(), .tp_link_test_off(),
        .tp_pol_corr_en()
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] op);
        i_host.xfer(op, 14, rsp);
    endtask

    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        i_host.xfer(op, 20, rsp);
        check(16'(rsp), 16'({exp, 1'b0}));
    endtask

    task automatic clear_seen;
        clr_seen = 1'b1;
        @(negedge clock);
        clr_seen = 1'b0;
    endtask

    task automatic events;
        {up_b, up_s, up_l} = 3'h7;
        @(negedge clock);
        {up_b, up_s, up_l} = 3'h0;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (10) @(negedge clock);
        check(16'({so, coltest_mask, up_alt_algo, tp_alt_algo}), 16'h8);
        check(16'({tp_pol_corr_en, tp_link_test_off}), 16'h0);
        $display("test reset done");
        wr(8'h0A);
        check(16'({coltest_mask, activity_monitor_alt}), 16'h2);
        wr(8'h09);
        check(16'({coltest_mask, activity_monitor_alt}), 16'h1);
        wr(8'h1F);
        check(16'({up_alt_algo, tp_alt_algo}), 16'h2);
        wr(8'h10);
        check(16'({up_alt_algo, tp_alt_algo}), 16'h3);
        $display("test options done");
        clear_seen();
        wr(8'h2F);
        check(16'({up_disabled, seen_idle}), 16'h3);
        wr(8'h3F);
        check(16'(up_disabled), 16'h0);
        for (p = 0; p < 8; p++) begin
            clear_seen();
            wr({rmsc_pkg::OP_TP_DIS, p[2:0]});
            check({tp_disabled, seen_rec}, {2{8'(1 << p)}});
            check(16'(dis4), p[0] ? 16'(1 << (p >> 1)) : 16'h0);
            clear_seen();
            wr({rmsc_pkg::OP_TP_EN, p[2:0]});
            check({tp_disabled, seen_fail}, 16'(1 << p));
            check(16'(dis4), 16'h0);
        end
        $display("test port enables done");
        wr({rmsc_pkg::OP_LT_DIS, 3'h3});
        check(16'(tp_link_test_off), 16'h08);
        rd(rmsc_pkg::RD_LINK, 8'h49);
        wr({rmsc_pkg::OP_LT_EN, 3'h3});
        check(16'(tp_link_test_off), 16'h00);
        wr({rmsc_pkg::OP_PL_EN, 3'h6});
        check(16'(tp_pol_corr_en), 16'h40);
        wr({rmsc_pkg::OP_PL_DIS, 3'h6});
        check(16'(tp_pol_corr_en), 16'h00);
        rd(rmsc_pkg::RD_PART, 8'hA5);
        rd(rmsc_pkg::RD_RATE, 8'h3C);
        rd(rmsc_pkg::RD_POL, 8'h96);
        jab = 1'b1;
        rd(rmsc_pkg::RD_JAB, 8'h80);
        rd(rmsc_pkg::RD_VER, 8'h5A);
        $display("test port reads done");
        events();
        rd(8'h89, 8'hF0);
        rd(8'h8D, 8'hF0);
        rd(8'h89, 8'hB0);
        rd(8'h8B, 8'hB0);
        rd(8'h89, 8'h80);
        events();
        up_conn = 1'b0;
        rd(8'h8F, 8'h70);
        rd(8'h89, 8'h00);
        $display("test uplink status done");
        test_sel = 1'b1;
        repeat (8) @(negedge clock);
        wr(8'h2F);
        check(16'(up_disabled), 16'h0);
        test_sel = 1'b0;
        repeat (8) @(negedge clock);
        wr(8'h2F);
        check(16'(up_disabled), 16'h1);
        $display("test select done");
        i_host.hold_si(1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        check(16'({so, up_alt_algo, tp_alt_algo, up_disabled}), 16'h8);
        rst_n = 1'b1;
        repeat (10) @(negedge clock);
        check(16'(tp_pol_corr_en), 16'hFF);
        i_host.hold_si(1'b1);
        repeat (8) @(negedge clock);
        rd(rmsc_pkg::RD_POL, 8'h96);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- verilog/rmsc_framer.sv ----
// start-bit framed serial receiver and transmitter
`timescale 1ns/1ps
`default_nettype none
module rmsc_framer (
    input  wire logic        clock,
    input  wire logic        rst_n,
    rmsc_ser_if.framer       f
);
    rmsc_pkg::rmsc_fr_type state_q, state_d;
    logic [3:0]            cnt_q, cnt_d;
    logic [7:0]            sh_q, sh_d;
    logic                  so_q, so_d;
    logic                  done_q, done_d;
    logic [7:0]            rxb_q, rxb_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        so_d    = so_q;
        done_d  = 1'b0;
        rxb_d   = rxb_q;
        unique case (state_q)
            rmsc_pkg::FR_IDLE: begin
                so_d = 1'b1;
                if (f.tx_load) begin
                    sh_d    = f.tx_byte;
                    state_d = rmsc_pkg::FR_START;
                end else if (f.edge_rise && !f.si_bit) begin
                    cnt_d   = 4'h0;
                    state_d = rmsc_pkg::FR_RX;
                end
            end
            rmsc_pkg::FR_RX: begin
                if (f.edge_rise) begin
                    sh_d  = {f.si_bit, sh_q[7:1]};
                    cnt_d = 4'(cnt_q + 4'h1);
                    if (cnt_q == rmsc_pkg::LAST_BIT) begin
                        done_d  = 1'b1;
                        rxb_d   = {f.si_bit, sh_q[7:1]};
                        state_d = rmsc_pkg::FR_IDLE;
                    end
                end
            end
            rmsc_pkg::FR_START: begin
                if (f.edge_rise) begin
                    so_d    = 1'b0;
                    cnt_d   = 4'h0;
                    state_d = rmsc_pkg::FR_TX;
                end
            end
            rmsc_pkg::FR_TX: begin
                if (f.edge_rise) begin
                    if (cnt_q == 4'(rmsc_pkg::DATA_BITS)) begin
                        so_d    = 1'b1;
                        state_d = rmsc_pkg::FR_IDLE;
                    end else begin
                        so_d  = sh_q[0];
                        sh_d  = {1'b1, sh_q[7:1]};
                        cnt_d = 4'(cnt_q + 4'h1);
                    end
                end
            end
        endcase
        if (!f.en) begin
            state_d = rmsc_pkg::FR_IDLE;
            so_d    = 1'b1;
            done_d  = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rmsc_pkg::FR_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            so_q    <= 1'b1;
            done_q  <= 1'b0;
            rxb_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            so_q    <= so_d;
            done_q  <= done_d;
            rxb_q   <= rxb_d;
        end
    end

    assign f.so      = so_q;
    assign f.rx_done = done_q;
    assign f.rx_byte = rxb_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence tx_start_s;
        state_q == rmsc_pkg::FR_START && f.edge_rise && f.en;
    endsequence

    so_idle_a: assert property (state_q == rmsc_pkg::FR_IDLE |-> so_q)
        else $error("response line not high while idle");
    tx_start_a: assert property (tx_start_s |=> !so_q)
        else $error("start bit not driven low");
    rx_msb_a: assert property (state_q == rmsc_pkg::FR_RX && f.edge_rise
        && f.en && cnt_q == rmsc_pkg::LAST_BIT
        |=> done_q && rxb_q[7] == $past(f.si_bit))
        else $error("last received bit not the msb");
endmodule
`default_nettype wire

// ---- verilog/rmsc_mgmt_serial.sv ----
// management serial command interpreter for the repeater core
// How it works
// - commands act only while test select low
// - host shifts commands in, responses shift out
// - bits sampled and launched on serial clock rise
// - each byte is start bit plus eight
// - data bits travel lsb first
// - options write latches mask and monitor select
// - uplink alternate algorithm until reset
// - all ports alternate algorithm together
// - uplink disable idles it, enable restores
// - port disable reconnects, enable of a disabled port forces link fail
// - per port link test disable and enable
// - per port polarity correction disable and enable
// - uplink status read clears three sticky flags
// - alternate uplink reads clear selectively
// - partition read returns one bit per port
// - rate error read one bit per port
// - link read one bit per port
// - polarity read one bit per port
// - select code maps to ports by variant
`timescale 1ns/1ps
`default_nettype none
module rmsc_mgmt_serial #(
    parameter int         PORTS   = 8,
    parameter logic [7:0] VERSION = 8'h3C // arbitrary value
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             sclk,
    input  wire logic             si,
    input  wire logic             test_sel,
    input  wire logic             up_connected,
    input  wire logic             up_rate_err_evt,
    input  wire logic             up_coltest_evt,
    input  wire logic             up_link_evt,
    input  wire logic             long_jabber_status,
    input  wire logic [PORTS-1:0] tp_connected,
    input  wire logic [PORTS-1:0] tp_rate_err,
    input  wire logic [PORTS-1:0] tp_link_pass,
    input  wire logic [PORTS-1:0] tp_pol_rev,
    output logic                  so,
    output logic                  coltest_mask,
    output logic                  activity_monitor_alt,
    output logic                  up_alt_algo,
    output logic                  tp_alt_algo,
    output logic                  up_disabled,
    output logic                  up_part_idle,
    output logic [PORTS-1:0]      tp_disabled,
    output logic [PORTS-1:0]      tp_reconnect,
    output logic [PORTS-1:0]      tp_link_fail,
    output logic [PORTS-1:0]      tp_link_test_off,
    output logic [PORTS-1:0]      tp_pol_corr_en
);
    // bit 0 serial clock, bit 1 command input, bit 2 test select
    logic [2:0]       s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic             rise;
    logic             exec;
    logic [7:0]       b;
    logic             mask_q, mask_d;
    logic             alt_q, alt_d;
    logic             upalg_q, upalg_d;
    logic             tpalg_q, tpalg_d;
    logic             updis_q, updis_d;
    logic             upidle_q, upidle_d;
    logic [PORTS-1:0] tpdis_q, tpdis_d;
    logic [PORTS-1:0] recon_q, recon_d;
    logic [PORTS-1:0] lfail_q, lfail_d;
    logic [PORTS-1:0] ltoff_q, ltoff_d;
    logic [PORTS-1:0] polen_q, polen_d;
    logic             stb_q, stb_d;
    logic             sts_q, sts_d;
    logic             stl_q, stl_d;
    logic             load_q, load_d;
    logic [7:0]       txb_q, txb_d;
    logic [2:0]       strap_q, strap_d;

    rmsc_ser_if ser ();

    rmsc_framer u_framer (
        .clock (clock),
        .rst_n (rst_n),
        .f     (ser)
    );

    function automatic logic [PORTS-1:0] sel_mask(input logic [2:0] c);
        logic [PORTS-1:0] m;
        m = '0;
        for (int i = 0; i < PORTS; i++) begin
            if (PORTS == 8)
                m[i] = (c == 3'(i));
            else
                m[i] = c[0] && (c[2:1] == 2'(i));
        end
        return m;
    endfunction

    function automatic logic [7:0] pad(input logic [PORTS-1:0] v);
        return 8'(v);
    endfunction

    // level follows once the second and third stage agree
    always_comb begin
        lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= rmsc_pkg::SYNC_RST;
            s2_q  <= rmsc_pkg::SYNC_RST;
            s3_q  <= rmsc_pkg::SYNC_RST;
            lvl_q <= rmsc_pkg::SYNC_RST;
        end else begin
            s1_q  <= {test_sel, si, sclk};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign rise = s2_q[0] && s3_q[0] && !lvl_q[0];
    assign exec = ser.rx_done && !lvl_q[2];
    assign b    = ser.rx_byte;

    assign ser.edge_rise = rise;
    assign ser.si_bit    = lvl_q[1];
    assign ser.en        = !lvl_q[2];
    assign ser.tx_load   = load_q;
    assign ser.tx_byte   = txb_q;

    always_comb begin
        logic clr_b;
        logic clr_s;
        logic clr_l;
        logic [PORTS-1:0] m;
        clr_b    = 1'b0;
        clr_s    = 1'b0;
        clr_l    = 1'b0;
        m        = sel_mask(b[2:0]);
        mask_d   = mask_q;
        alt_d    = alt_q;
        upalg_d  = upalg_q;
        tpalg_d  = tpalg_q;
        updis_d  = updis_q;
        upidle_d = 1'b0;
        tpdis_d  = tpdis_q;
        recon_d  = '0;
        lfail_d  = '0;
        ltoff_d  = ltoff_q;
        polen_d  = polen_q;
        load_d   = 1'b0;
        txb_d    = txb_q;
        strap_d  = strap_q;
        if (strap_q != rmsc_pkg::STRAP_CYC) begin
            strap_d = 3'(strap_q + 3'h1);
            if (strap_d == rmsc_pkg::STRAP_CYC && !lvl_d[1])
                polen_d = '1;
        end
        if (exec) begin
            case (b)
                rmsc_pkg::OP_UP_ALT: upalg_d = 1'b1;
                rmsc_pkg::OP_TP_ALT: tpalg_d = 1'b1;
                rmsc_pkg::OP_UP_DIS: begin
                    updis_d  = 1'b1;
                    upidle_d = 1'b1;
                end
                rmsc_pkg::OP_UP_EN: updis_d = 1'b0;
                rmsc_pkg::RD_UP_ALL, rmsc_pkg::RD_UP_SL,
                rmsc_pkg::RD_UP_B, rmsc_pkg::RD_UP_NO: begin
                    load_d = 1'b1;
                    txb_d  = {up_connected, stb_q, sts_q, stl_q,
                              4'h0};
                    clr_b  = (b == rmsc_pkg::RD_UP_ALL)
                          || (b == rmsc_pkg::RD_UP_B);
                    clr_s  = (b == rmsc_pkg::RD_UP_ALL)
                          || (b == rmsc_pkg::RD_UP_SL);
                    clr_l  = clr_s;
                end
                rmsc_pkg::RD_PART: begin
                    load_d = 1'b1;
                    txb_d  = pad(tp_connected);
                end
                rmsc_pkg::RD_RATE: begin
                    load_d = 1'b1;
                    txb_d  = pad(tp_rate_err);
                end
                rmsc_pkg::RD_LINK: begin
                    load_d = 1'b1;
                    txb_d  = pad(tp_link_pass | ltoff_q);
                end
                rmsc_pkg::RD_POL: begin
                    load_d = 1'b1;
                    txb_d  = pad(tp_pol_rev);
                end
                rmsc_pkg::RD_JAB: begin
                    load_d = 1'b1;
                    txb_d  = {long_jabber_status, 7'h00};
                end
                rmsc_pkg::RD_VER: begin
                    load_d = 1'b1;
                    txb_d  = VERSION;
                end
                default: begin
                    if ((b & rmsc_pkg::OPT_MASK) == rmsc_pkg::OP_OPT) begin
                        mask_d = b[rmsc_pkg::OPT_S_BIT];
                        alt_d  = b[rmsc_pkg::OPT_A_BIT];
                    end else begin
                        case (b[7:3])
                            rmsc_pkg::OP_TP_DIS: begin
                                tpdis_d = tpdis_q | m;
                                recon_d = m;
                            end
                            rmsc_pkg::OP_TP_EN: begin
                                lfail_d = m & tpdis_q;
                                tpdis_d = tpdis_q & ~m;
                            end
                            rmsc_pkg::OP_LT_DIS:
                                ltoff_d = ltoff_q | m;
                            rmsc_pkg::OP_LT_EN:
                                ltoff_d = ltoff_q & ~m;
                            rmsc_pkg::OP_PL_DIS:
                                polen_d = polen_q & ~m;
                            rmsc_pkg::OP_PL_EN:
                                polen_d = polen_q | m;
                            default: ;
                        endcase
                    end
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        stb_d = up_rate_err_evt | (stb_q & ~clr_b);
        sts_d = up_coltest_evt | (sts_q & ~clr_s);
        stl_d = up_link_evt | (stl_q & ~clr_l);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_q   <= 1'b0;
            alt_q    <= 1'b0;
            upalg_q  <= 1'b0;
            tpalg_q  <= 1'b0;
            updis_q  <= 1'b0;
            upidle_q <= 1'b0;
            tpdis_q  <= '0;
            recon_q  <= '0;
            lfail_q  <= '0;
            ltoff_q  <= '0;
            polen_q  <= '0;
            stb_q    <= 1'b0;
            sts_q    <= 1'b0;
            stl_q    <= 1'b0;
            load_q   <= 1'b0;
            txb_q    <= 8'h00;
            strap_q  <= 3'h0;
        end else begin
            mask_q   <= mask_d;
            alt_q    <= alt_d;
            upalg_q  <= upalg_d;
            tpalg_q  <= tpalg_d;
            updis_q  <= updis_d;
            upidle_q <= upidle_d;
            tpdis_q  <= tpdis_d;
            recon_q  <= recon_d;
            lfail_q  <= lfail_d;
            ltoff_q  <= ltoff_d;
            polen_q  <= polen_d;
            stb_q    <= stb_d;
            sts_q    <= sts_d;
            stl_q    <= stl_d;
            load_q   <= load_d;
            txb_q    <= txb_d;
            strap_q  <= strap_d;
        end
    end

    assign so                   = ser.so;
    assign coltest_mask         = mask_q;
    assign activity_monitor_alt = alt_q;
    assign up_alt_algo          = upalg_q;
    assign tp_alt_algo          = tpalg_q;
    assign up_disabled          = updis_q;
    assign up_part_idle         = upidle_q;
    assign tp_disabled          = tpdis_q;
    assign tp_reconnect         = recon_q;
    assign tp_link_fail         = lfail_q;
    assign tp_link_test_off     = ltoff_q;
    assign tp_pol_corr_en       = polen_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence idle_pulse_s;
        updis_q && upidle_q ##1 !upidle_q;
    endsequence

    test_gate_a: assert property (lvl_q[2] |=> !ser.rx_done && !load_q
        && $stable(updis_q) && $stable(tpdis_q))
        else $error("command acted while test select high");
    opt_latch_a: assert property (exec
        && (b & rmsc_pkg::OPT_MASK) == rmsc_pkg::OP_OPT
        |=> mask_q == $past(b[1]) && alt_q == $past(b[0]))
        else $error("options not latched");
    up_alt_a: assert property (upalg_q |=> upalg_q)
        else $error("uplink algorithm reverted without reset");
    tp_alt_a: assert property (exec && b == rmsc_pkg::OP_TP_ALT
        |=> tpalg_q)
        else $error("port algorithm not switched");
    up_dis_a: assert property (exec && b == rmsc_pkg::OP_UP_DIS
        |=> idle_pulse_s)
        else $error("uplink disable sequence wrong");
    tp_en_a: assert property (exec && b[7:3] == rmsc_pkg::OP_TP_EN
        |=> lfail_q == ($past(sel_mask(b[2:0])) & $past(tpdis_q))
        && (tpdis_q & $past(sel_mask(b[2:0]))) == '0)
        else $error("port enable wrong");
    sticky_clr_a: assert property (exec && b == rmsc_pkg::RD_UP_ALL
        && !up_rate_err_evt && !up_coltest_evt && !up_link_evt
        |=> !stb_q && !sts_q && !stl_q)
        else $error("sticky flags not cleared");
    set_wins_a: assert property (up_rate_err_evt |=> stb_q)
        else $error("rate error event lost");
    part_read_a: assert property (exec && b == rmsc_pkg::RD_PART
        |=> load_q && txb_q == pad($past(tp_connected)))
        else $error("partition read byte wrong");
endmodule
`default_nettype wire

// ---- verilog/rmsc_pkg.sv ----
// constants for the repeater management serial command block
package rmsc_pkg;
    localparam int        DATA_BITS  = 8;
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam logic [2:0] SYNC_RST  = 3'h6;
    localparam logic [2:0] STRAP_CYC = 3'h4;
    localparam logic [7:0] OPT_MASK  = 8'hFC;
    localparam logic [7:0] OP_OPT    = 8'h08;
    localparam int        OPT_S_BIT  = 1;
    localparam int        OPT_A_BIT  = 0;
    localparam logic [7:0] OP_UP_ALT = 8'h1F;
    localparam logic [7:0] OP_TP_ALT = 8'h10;
    localparam logic [7:0] OP_UP_DIS = 8'h2F;
    localparam logic [7:0] OP_UP_EN  = 8'h3F;
    localparam logic [4:0] OP_TP_DIS = 5'h04;
    localparam logic [4:0] OP_TP_EN  = 5'h06;
    localparam logic [4:0] OP_LT_DIS = 5'h08;
    localparam logic [4:0] OP_LT_EN  = 5'h0A;
    localparam logic [4:0] OP_PL_DIS = 5'h0C;
    localparam logic [4:0] OP_PL_EN  = 5'h0E;
    localparam logic [7:0] RD_UP_ALL = 8'h8F;
    localparam logic [7:0] RD_UP_SL  = 8'h8B;
    localparam logic [7:0] RD_UP_B   = 8'h8D;
    localparam logic [7:0] RD_UP_NO  = 8'h89;
    localparam logic [7:0] RD_PART   = 8'h80;
    localparam logic [7:0] RD_RATE   = 8'hA0;
    localparam logic [7:0] RD_LINK   = 8'hD0;
    localparam logic [7:0] RD_POL    = 8'hE0;
    localparam logic [7:0] RD_JAB    = 8'hF0;
    localparam logic [7:0] RD_VER    = 8'hFF;
    typedef enum logic [3:0] {
        FR_IDLE  = 4'h1,
        FR_RX    = 4'h2,
        FR_START = 4'h4,
        FR_TX    = 4'h8
    } rmsc_fr_type;
endpackage

// ---- verilog/rmsc_ser_if.sv ----
// carrier between the command logic and the serial framer
`timescale 1ns/1ps
`default_nettype none
interface rmsc_ser_if;
    logic       edge_rise;
    logic       si_bit;
    logic       en;
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       rx_done;
    logic [7:0] rx_byte;
    logic       so;
    modport framer (input edge_rise, si_bit, en, tx_load, tx_byte,
                    output rx_done, rx_byte, so);
    modport ctrl (output edge_rise, si_bit, en, tx_load, tx_byte,
                  input rx_done, rx_byte, so);
endinterface
`default_nettype wire
